/* rtl/rftc_config_regs.sv */
// APB register bank for the transceiver tuning and test settings
// How it works
// - Seed field picks calibration DAC start value code plus one; resets to 5.
// - Upper power nibble sets strong array level, zero is off; resets to 0.
// - Lower power nibble sets weak array level, zero is off; resets to 15.
// - Upper matching nibble selects receive capacitor code; resets to 0.
// - Lower matching nibble selects transmit capacitor code; resets to 0.
// - Phase trim is an 8-bit signed value passed through; resets to 0.
// - Gain trim is an 8-bit signed value passed through; resets to 0.
// - Mask bits 7..4 sleep amplifier, oscillator, divider, pump in policy 2.
// - Mask bits 3..0 sleep front end, VGA, filter, converter in policy 2.
// - Forced DAC nibble resets to 4 and applies only with loop open.
// - Forced pump current nibble resets to 13.
// - Loop control bit 7 opens the PLL loop when 1; resets to 0.
// - Bit 6 picks forced pump current instead of calibrated one.
// - Bit 5 picks forced 5-bit oscillator array; forced value resets to 16.
// - Writing 1 to calibration bit 7 starts calibration; reads 0 when idle.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module rftc_config_regs #(
  parameter int CAL_CYCLES = 64
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rftc_pkg::APB_AW-1:0] paddr,
  input wire logic [rftc_pkg::APB_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [rftc_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rftc_pkg::rftc_calib_t calib,
  output rftc_pkg::rftc_analog_t analog,
  output logic cal_start
);

  localparam logic [15:0] CAL_LAST = 16'(CAL_CYCLES - 1);

  logic [7:0] pll_calibration_setup;
  logic [7:0] output_power_levels;
  logic [7:0] antenna_tuning_caps;
  logic [7:0] iq_skew_trim;
  logic [7:0] iq_amplitude_trim;
  logic [7:0] block_sleep_mask;
  logic [7:0] loop_override_values;
  logic [7:0] loop_override_control;
  logic [1:0] sleep_policy;
  logic cal_active;
  logic [15:0] cal_count;
  logic [rftc_pkg::APB_DW-1:0] next_rdata;
  logic next_hit;
  logic setup;
  logic wr_en;
  logic cal_go;
  logic manual_sleep;
  logic [7:0] sleep_gated;
  rftc_pkg::rftc_analog_t next_analog;

  // Bus phase decode; the slave never inserts wait states
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign pready = 1'b1;

  // Read data and address hit for the current address
  always_comb begin
    next_hit = 1'b1;
    next_rdata = '0;
    case (paddr)
      rftc_pkg::ADDR_PLL_CAL: begin
        next_rdata[rftc_pkg::CAL_START_BIT] = cal_active;
        next_rdata[rftc_pkg::CAL_KEEP_MSB:0] =
          pll_calibration_setup[rftc_pkg::CAL_KEEP_MSB:0];
      end
      rftc_pkg::ADDR_OUT_POWER: begin
        next_rdata[rftc_pkg::REG_W-1:0] = output_power_levels;
      end
      rftc_pkg::ADDR_MATCH: begin
        next_rdata[rftc_pkg::REG_W-1:0] = antenna_tuning_caps;
      end
      rftc_pkg::ADDR_IQ_SKEW: begin
        next_rdata[rftc_pkg::REG_W-1:0] = iq_skew_trim;
      end
      rftc_pkg::ADDR_IQ_AMP: begin
        next_rdata[rftc_pkg::REG_W-1:0] = iq_amplitude_trim;
      end
      rftc_pkg::ADDR_SLEEP_MASK: begin
        next_rdata[rftc_pkg::REG_W-1:0] = block_sleep_mask;
      end
      rftc_pkg::ADDR_LOOP_VAL: begin
        next_rdata[rftc_pkg::REG_W-1:0] = loop_override_values;
      end
      rftc_pkg::ADDR_LOOP_CTL: begin
        next_rdata[rftc_pkg::REG_W-1:0] = loop_override_control;
      end
      rftc_pkg::ADDR_SLEEP_POLICY: begin
        next_rdata[rftc_pkg::POLICY_MSB:0] = sleep_policy;
      end
      default: begin
        next_hit = 1'b0;
      end
    endcase
  end

  // Unmapped addresses answer with an error in the access phase
  assign pslverr = psel && penable && !next_hit;

  // Read data is captured in the setup phase, shown in the access phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (setup) begin
      prdata <= next_rdata;
    end
  end

  // Software writes into the configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pll_calibration_setup <= rftc_pkg::RST_PLL_CAL;
      output_power_levels <= rftc_pkg::RST_OUT_POWER;
      antenna_tuning_caps <= rftc_pkg::RST_MATCH;
      iq_skew_trim <= rftc_pkg::RST_TRIM;
      iq_amplitude_trim <= rftc_pkg::RST_TRIM;
      block_sleep_mask <= rftc_pkg::RST_SLEEP_MASK;
      loop_override_values <= rftc_pkg::RST_LOOP_VAL;
      loop_override_control <= rftc_pkg::RST_LOOP_CTL;
      sleep_policy <= rftc_pkg::RST_POLICY;
    end else if (wr_en) begin
      case (paddr)
        rftc_pkg::ADDR_PLL_CAL: begin
          // Start bit is never stored; it reads back as the busy flag
          pll_calibration_setup <=
            {1'b0, pwdata[rftc_pkg::CAL_KEEP_MSB:0]};
        end
        rftc_pkg::ADDR_OUT_POWER: begin
          output_power_levels <= pwdata[rftc_pkg::REG_W-1:0];
        end
        rftc_pkg::ADDR_MATCH: begin
          antenna_tuning_caps <= pwdata[rftc_pkg::REG_W-1:0];
        end
        rftc_pkg::ADDR_IQ_SKEW: begin
          iq_skew_trim <= pwdata[rftc_pkg::REG_W-1:0];
        end
        rftc_pkg::ADDR_IQ_AMP: begin
          iq_amplitude_trim <= pwdata[rftc_pkg::REG_W-1:0];
        end
        rftc_pkg::ADDR_SLEEP_MASK: begin
          block_sleep_mask <= pwdata[rftc_pkg::REG_W-1:0];
        end
        rftc_pkg::ADDR_LOOP_VAL: begin
          loop_override_values <= pwdata[rftc_pkg::REG_W-1:0];
        end
        rftc_pkg::ADDR_LOOP_CTL: begin
          loop_override_control <= pwdata[rftc_pkg::REG_W-1:0];
        end
        rftc_pkg::ADDR_SLEEP_POLICY: begin
          sleep_policy <= pwdata[rftc_pkg::POLICY_MSB:0];
        end
        default: begin
        end
      endcase
    end
  end

  // A start request counts only as a rise of the busy bit
  assign cal_go = wr_en && (paddr == rftc_pkg::ADDR_PLL_CAL) &&
                  pwdata[rftc_pkg::CAL_START_BIT] && !cal_active;

  // Calibration run: pulse the start, then stay busy for a fixed time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cal_active <= 1'b0;
      cal_count <= 16'h0000;
      cal_start <= 1'b0;
    end else begin
      cal_start <= cal_go;
      if (cal_go) begin
        cal_active <= 1'b1;
        cal_count <= 16'h0000;
      end else if (cal_active) begin
        if (cal_count == CAL_LAST) begin
          cal_active <= 1'b0;
        end else begin
          cal_count <= cal_count + 16'h0001;
        end
      end
    end
  end

  // Sleep mask only counts in the manual sleep policy
  assign manual_sleep = (sleep_policy == rftc_pkg::SLEEP_POLICY_MANUAL);
  for (genvar i = 0; i < rftc_pkg::REG_W; i++) begin : g_sleep
    assign sleep_gated[i] = manual_sleep && block_sleep_mask[i];
  end

  // Settings for the analog side, decoded from the registers
  always_comb begin
    next_analog.dac_seed_start =
      {1'b0, pll_calibration_setup[rftc_pkg::SEED_MSB:0]} +
      rftc_pkg::SEED_OFFSET;
    next_analog.strong_array_level =
      output_power_levels[rftc_pkg::HI_MSB:rftc_pkg::HI_LSB];
    next_analog.weak_array_level =
      output_power_levels[rftc_pkg::LO_MSB:rftc_pkg::LO_LSB];
    next_analog.rx_match_cap =
      antenna_tuning_caps[rftc_pkg::HI_MSB:rftc_pkg::HI_LSB];
    next_analog.tx_match_cap =
      antenna_tuning_caps[rftc_pkg::LO_MSB:rftc_pkg::LO_LSB];
    next_analog.phase_trim = iq_skew_trim;
    next_analog.gain_trim = iq_amplitude_trim;
    next_analog.block_sleep = sleep_gated;
    next_analog.loop_open =
      loop_override_control[rftc_pkg::LOOP_OPEN_BIT];
    next_analog.cal_dac_value = calib.cal_dac;
    if (loop_override_control[rftc_pkg::LOOP_OPEN_BIT]) begin
      next_analog.cal_dac_value =
        loop_override_values[rftc_pkg::HI_MSB:rftc_pkg::HI_LSB];
    end
    next_analog.pump_current = calib.pump_current;
    if (loop_override_control[rftc_pkg::PUMP_FORCE_BIT]) begin
      next_analog.pump_current =
        loop_override_values[rftc_pkg::LO_MSB:rftc_pkg::LO_LSB];
    end
    next_analog.osc_array = calib.osc_array;
    if (loop_override_control[rftc_pkg::OSC_FORCE_BIT]) begin
      next_analog.osc_array =
        loop_override_control[rftc_pkg::OSC_MSB:0];
    end
  end

  // Registered drive into the analog front end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      analog <= '0;
    end else begin
      analog <= next_analog;
    end
  end

  // Checks on the register bank
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wr(logic [7:0] a);
    psel && penable && pwrite && pstrb[0] && (paddr == a);
  endsequence

  sequence s_out_reset;
    $rose(rst_n);
  endsequence

  property p_seed;
    s_out_reset |-> pll_calibration_setup[rftc_pkg::SEED_MSB:0] == 3'h5
      ##2 analog.dac_seed_start == 4'h6;
  endproperty
  a_seed: assert property (p_seed)
    else $error("seed start value not code plus one");

  property p_seed_track;
    s_wr(rftc_pkg::ADDR_PLL_CAL) |-> ##2
      analog.dac_seed_start == 4'($past(pwdata[2:0], 2)) + 4'h1;
  endproperty
  a_seed_track: assert property (p_seed_track)
    else $error("seed start value does not follow write");

  property p_strong;
    s_out_reset |-> ##1 analog.strong_array_level == 4'h0;
  endproperty
  a_strong: assert property (p_strong)
    else $error("strong array level wrong after reset");

  property p_weak;
    s_out_reset |-> ##1 analog.weak_array_level == 4'hf;
  endproperty
  a_weak: assert property (p_weak)
    else $error("weak array level wrong after reset");

  property p_rx_cap;
    s_wr(rftc_pkg::ADDR_MATCH) |-> ##2
      analog.rx_match_cap == $past(pwdata[7:4], 2);
  endproperty
  a_rx_cap: assert property (p_rx_cap)
    else $error("receive capacitor code not from upper nibble");

  property p_tx_cap;
    s_wr(rftc_pkg::ADDR_MATCH) |-> ##2
      analog.tx_match_cap == $past(pwdata[3:0], 2);
  endproperty
  a_tx_cap: assert property (p_tx_cap)
    else $error("transmit capacitor code not from lower nibble");

  property p_phase;
    s_wr(rftc_pkg::ADDR_IQ_SKEW) |-> ##2
      analog.phase_trim == $past(pwdata[7:0], 2);
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase trim not passed through");

  property p_gain;
    s_out_reset |-> ##1 analog.gain_trim == 8'h00;
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain trim not zero after reset");

  property p_sleep_hi;
    sleep_policy != 2'h2 |=> analog.block_sleep[7:4] == 4'h0;
  endproperty
  a_sleep_hi: assert property (p_sleep_hi)
    else $error("upper blocks asleep outside manual policy");

  property p_sleep_lo;
    sleep_policy == 2'h2 |=>
      analog.block_sleep[3:0] == $past(block_sleep_mask[3:0]);
  endproperty
  a_sleep_lo: assert property (p_sleep_lo)
    else $error("lower sleep bits do not follow mask");

  property p_dac_force;
    loop_override_control[7] |=>
      analog.cal_dac_value == $past(loop_override_values[7:4]);
  endproperty
  a_dac_force: assert property (p_dac_force)
    else $error("forced DAC value not applied with loop open");

  property p_pump_reset;
    s_out_reset |-> loop_override_values[3:0] == 4'hd;
  endproperty
  a_pump_reset: assert property (p_pump_reset)
    else $error("forced pump current wrong after reset");

  property p_loop;
    ##1 analog.loop_open == $past(loop_override_control[7]);
  endproperty
  a_loop: assert property (p_loop)
    else $error("loop open output does not follow control bit");

  property p_pump_sel;
    !loop_override_control[6] |=>
      analog.pump_current == $past(calib.pump_current);
  endproperty
  a_pump_sel: assert property (p_pump_sel)
    else $error("calibrated pump current not used");

  property p_osc_sel;
    s_out_reset |-> loop_override_control[4:0] == 5'h10 ##1
      analog.osc_array == $past(calib.osc_array);
  endproperty
  a_osc_sel: assert property (p_osc_sel)
    else $error("oscillator array selection wrong after reset");

  sequence s_cal_go;
    s_wr(rftc_pkg::ADDR_PLL_CAL) ##0 pwdata[7] ##0 !cal_active;
  endsequence

  property p_cal;
    s_cal_go |=> cal_start && cal_active ##1 !cal_start;
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibration start not taken");

  property p_cal_idle;
    setup && paddr == rftc_pkg::ADDR_PLL_CAL && !cal_active |=>
      prdata[7] == 1'b0;
  endproperty
  a_cal_idle: assert property (p_cal_idle)
    else $error("start bit reads 1 while idle");

  property p_readback;
    s_wr(rftc_pkg::ADDR_LOOP_VAL) |=>
      loop_override_values == $past(pwdata[7:0]);
  endproperty
  a_readback: assert property (p_readback)
    else $error("register does not hold written value");

endmodule

/* shared/rftc_pkg.sv */
// Constants and carrier types for the RF tuning configuration bank
package rftc_pkg;

  // Bus geometry
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int REG_W = 8;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_PLL_CAL = 8'h1b;
  localparam logic [7:0] IDX_OUT_POWER = 8'h1c;
  localparam logic [7:0] IDX_MATCH = 8'h1d;
  localparam logic [7:0] IDX_IQ_SKEW = 8'h1e;
  localparam logic [7:0] IDX_IQ_AMP = 8'h1f;
  localparam logic [7:0] IDX_SLEEP_MASK = 8'h20;
  localparam logic [7:0] IDX_LOOP_VAL = 8'h21;
  localparam logic [7:0] IDX_LOOP_CTL = 8'h22;
  localparam logic [7:0] IDX_SLEEP_POLICY = 8'h3c;

  // Byte addresses
  localparam logic [7:0] ADDR_PLL_CAL = 8'({IDX_PLL_CAL, 2'b00});
  localparam logic [7:0] ADDR_OUT_POWER = 8'({IDX_OUT_POWER, 2'b00});
  localparam logic [7:0] ADDR_MATCH = 8'({IDX_MATCH, 2'b00});
  localparam logic [7:0] ADDR_IQ_SKEW = 8'({IDX_IQ_SKEW, 2'b00});
  localparam logic [7:0] ADDR_IQ_AMP = 8'({IDX_IQ_AMP, 2'b00});
  localparam logic [7:0] ADDR_SLEEP_MASK = 8'({IDX_SLEEP_MASK, 2'b00});
  localparam logic [7:0] ADDR_LOOP_VAL = 8'({IDX_LOOP_VAL, 2'b00});
  localparam logic [7:0] ADDR_LOOP_CTL = 8'({IDX_LOOP_CTL, 2'b00});
  localparam logic [7:0] ADDR_SLEEP_POLICY = 8'({IDX_SLEEP_POLICY, 2'b00});

  // Field positions
  localparam int HI_MSB = 7;
  localparam int HI_LSB = 4;
  localparam int LO_MSB = 3;
  localparam int LO_LSB = 0;
  localparam int SEED_MSB = 2;
  localparam int CAL_START_BIT = 7;
  localparam int CAL_KEEP_MSB = 6;
  localparam int LOOP_OPEN_BIT = 7;
  localparam int PUMP_FORCE_BIT = 6;
  localparam int OSC_FORCE_BIT = 5;
  localparam int OSC_MSB = 4;
  localparam int POLICY_MSB = 1;

  // Sleep mask bit positions
  localparam int AMPLIFIER_SLEEP = 7;
  localparam int OSCILLATOR_SLEEP = 6;
  localparam int DIVIDER_GROUP_SLEEP = 5;
  localparam int PUMP_SLEEP = 4;
  localparam int FRONT_END_SLEEP = 3;
  localparam int VARIABLE_GAIN_SLEEP = 2;
  localparam int IMAGE_FILTER_SLEEP = 1;
  localparam int CONVERTER_SLEEP = 0;

  // Codes
  localparam logic [1:0] SLEEP_POLICY_MANUAL = 2'h2;
  localparam logic [3:0] SEED_OFFSET = 4'h1;

  // Field reset values
  localparam logic [2:0] RST_SEED = 3'h5;
  localparam logic [3:0] RST_STRONG = 4'h0;
  localparam logic [3:0] RST_WEAK = 4'hf;
  localparam logic [3:0] RST_CAP = 4'h0;
  localparam logic [7:0] RST_TRIM = 8'h00;
  localparam logic [7:0] RST_SLEEP_MASK = 8'h00;
  localparam logic [3:0] RST_DAC_FORCED = 4'h4;
  localparam logic [3:0] RST_PUMP_FORCED = 4'hd;
  localparam logic [4:0] RST_OSC_FORCED = 5'h10;
  localparam logic [1:0] RST_POLICY = 2'h0;

  // Register reset values
  localparam logic [7:0] RST_PLL_CAL = {5'h00, RST_SEED};
  localparam logic [7:0] RST_OUT_POWER = {RST_STRONG, RST_WEAK};
  localparam logic [7:0] RST_MATCH = {RST_CAP, RST_CAP};
  localparam logic [7:0] RST_LOOP_VAL = {RST_DAC_FORCED, RST_PUMP_FORCED};
  localparam logic [7:0] RST_LOOP_CTL = {3'h0, RST_OSC_FORCED};

  // Values delivered by the calibration engine
  typedef struct packed {
    logic [3:0] cal_dac;
    logic [3:0] pump_current;
    logic [4:0] osc_array;
  } rftc_calib_t;

  // Settings driven into the analog front end
  typedef struct packed {
    logic [3:0] dac_seed_start;
    logic [3:0] strong_array_level;
    logic [3:0] weak_array_level;
    logic [3:0] rx_match_cap;
    logic [3:0] tx_match_cap;
    logic [7:0] phase_trim;
    logic [7:0] gain_trim;
    logic [7:0] block_sleep;
    logic loop_open;
    logic [3:0] cal_dac_value;
    logic [3:0] pump_current;
    logic [4:0] osc_array;
  } rftc_analog_t;

endpackage

/* verification/tb_rftc_config_regs.sv */
// Self-checking bench for the RF tuning configuration register bank
`timescale 1ns/1ps
module tb_rftc_config_regs;
  localparam int CAL_N = 12;
  logic clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [rftc_pkg::APB_AW-1:0] paddr;
  logic [rftc_pkg::APB_DW-1:0] pwdata;
  logic [3:0] pstrb;
  logic [rftc_pkg::APB_DW-1:0] prdata;
  logic pready;
  logic pslverr;
  rftc_pkg::rftc_calib_t calib;
  rftc_pkg::rftc_analog_t analog;
  logic cal_start;
  int error_cnt;
  int samples_checked;
  int pulse_cnt = 0;
  logic [31:0] q;
  logic e;
  logic [7:0] addr_tab [9] = '{8'h6c, 8'h70, 8'h74, 8'h78, 8'h7c, 8'h80,
                               8'h84, 8'h88, 8'hf0};
  logic [7:0] rst_tab [9] = '{8'h05, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00,
                              8'h4d, 8'h10, 8'h00};
  logic [7:0] pat_tab [8] = '{8'h7a, 8'ha3, 8'hc5, 8'h80, 8'h7f, 8'ha5,
                              8'he2, 8'h1b};

  rftc_config_regs #(.CAL_CYCLES(CAL_N)) u_rftc_config_regs (
    .clk(clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .calib(calib),
    .analog(analog),
    .cal_start(cal_start)
  );

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Counts cycles in which the calibration start pulse is high
  always @(posedge clk) begin
    if (cal_start === 1'b1) pulse_cnt++;
  end

  // Compares one value and reports a mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer: setup, access, wait for pready, then release
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rq, output logic re);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // The wait ends when pready is high; only the watchdog ends a wait that pready never answers
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Mapped write that must not raise an error
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d}, 4'h1, q, e);
    chk({31'h0, e}, 32'h0, "write error flag");
  endtask

  // Mapped read compared against an expected byte
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 32'h0, 4'h0, q, e);
    chk(q, {24'h0, exp}, $sformatf("read %h", a));
    chk({31'h0, e}, 32'h0, "read error flag");
  endtask

  // Lets a register write reach the analog outputs
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Prints the counts and the verdict, then stops
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hung transfer
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end

  // Main sequence
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
    calib = '{cal_dac: 4'h9, pump_current: 4'h3, osc_array: 5'h0b};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values of every register and of seven of the decoded outputs
    for (int i = 0; i < 9; i++) rd_chk(addr_tab[i], rst_tab[i]);
    chk(32'(analog.dac_seed_start), 32'h6, "seed start");
    chk(32'(analog.strong_array_level), 32'h0, "strong");
    chk(32'(analog.weak_array_level), 32'hf, "weak");
    chk(32'(analog.block_sleep), 32'h0, "sleep");
    chk(32'(analog.cal_dac_value), 32'h9, "dac calib");
    chk(32'(analog.pump_current), 32'h3, "pump calib");
    chk(32'(analog.osc_array), 32'h0b, "osc calib");
    // Write every register but the sleep policy, then read those eight back to catch aliasing
    for (int i = 0; i < 8; i++) wr(addr_tab[i], pat_tab[i]);
    for (int i = 0; i < 8; i++) rd_chk(addr_tab[i], pat_tab[i]);
    settle();
    chk(32'(analog.dac_seed_start), 32'h3, "seed 2");
    chk(32'(analog.strong_array_level), 32'ha, "strong a");
    chk(32'(analog.weak_array_level), 32'h3, "weak 3");
    chk(32'(analog.rx_match_cap), 32'hc, "rx cap");
    chk(32'(analog.tx_match_cap), 32'h5, "tx cap");
    chk(32'(analog.phase_trim), 32'h80, "phase min");
    chk(32'(analog.gain_trim), 32'h7f, "gain max");
    chk(32'(analog.loop_open), 32'h0, "loop closed");
    chk(32'(analog.cal_dac_value), 32'h9, "dac closed");
    chk(32'(analog.pump_current), 32'h3, "pump calib");
    chk(32'(analog.osc_array), 32'h0b, "osc calib");
    // All three overrides and the open loop at once
    wr(8'h88, 8'hfb);
    settle();
    chk(32'(analog.loop_open), 32'h1, "loop open");
    chk(32'(analog.cal_dac_value), 32'he, "dac forced");
    chk(32'(analog.pump_current), 32'h2, "pump forced");
    chk(32'(analog.osc_array), 32'h1b, "osc forced");
    // Every seed code
    for (int c = 0; c < 8; c++) begin
      wr(8'h6c, 8'(c));
      settle();
      chk(32'(analog.dac_seed_start), 32'(c + 1), "seed");
    end
    // Mask acts only under the manual sleep policy
    for (int p = 0; p < 4; p++) begin
      wr(8'hf0, 8'(p));
      settle();
      chk(32'(analog.block_sleep), (p == 2) ? 32'ha5 : 32'h0,
          "sleep gate");
    end
    // Manual policy again, so the new mask reaches the outputs
    wr(8'hf0, 8'h02);
    wr(8'h80, 8'h5a);
    settle();
    chk(32'(analog.block_sleep), 32'h5a, "sleep halves");
    // Unmapped address and a write with its byte strobe off
    xfer(1'b1, 8'h8c, 32'h77, 4'h1, q, e);
    chk({31'h0, e}, 32'h1, "unmapped write err");
    xfer(1'b0, 8'h8c, 32'h0, 4'h0, q, e);
    chk({31'h0, e}, 32'h1, "unmapped read err");
    chk(q, 32'h0, "unmapped data");
    xfer(1'b1, 8'h70, 32'h11, 4'he, q, e);
    rd_chk(8'h70, 8'ha3);
    // Software drives power with the weak nibble alone
    wr(8'h70, 8'h0c);
    settle();
    chk(32'(analog.strong_array_level), 32'h0, "strong off");
    chk(32'(analog.weak_array_level), 32'hc, "weak only");
    // Calibration start, busy read, start refused while busy
    wr(8'h6c, 8'h83);
    repeat (3) @(posedge clk);
    chk(32'(pulse_cnt), 32'h1, "one start pulse");
    rd_chk(8'h6c, 8'h83);
    wr(8'h6c, 8'h83);
    repeat (3) @(posedge clk);
    chk(32'(pulse_cnt), 32'h1, "start while busy");
    repeat (CAL_N + 4) @(posedge clk);
    rd_chk(8'h6c, 8'h03);
    wr(8'h6c, 8'h85);
    repeat (3) @(posedge clk);
    chk(32'(pulse_cnt), 32'h2, "restart when idle");
    // Second reset mid-run restores the defaults
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) rd_chk(addr_tab[i], rst_tab[i]);
    final_report();
  end
endmodule
